// >>> design/bade_regs.svh
`ifndef BADE_REGS_SVH
`define BADE_REGS_SVH
`define BADE_OP_ADDR    8'h22
`define BADE_OP_ADDTW   8'h72
`define BADE_OP_DIVMR   8'ha9
`define BADE_OP_DIVDIR  8'hb9
`define BADE_OP_DIVIMM  8'h39
`define BADE_CC_OVF     0
`define BADE_CC_LINK    3
`define BADE_WORD_STEP  16'h0002
`define BADE_REG_HI     3'h7
`define BADE_CC_RESET   8'h00
`define BADE_WORD_MAX   17'h0ffff
`define BADE_DWORD_MAX  33'h0ffffffff
`endif

// >>> design/bade_pkg.sv
package bade_pkg;
   typedef struct packed {
      logic [7:0] opcode;
      logic       ind1;
      logic [2:0] firstRegField;
      logic       ind2;
      logic [2:0] secondRegField;
   } bade_instr_t;

   typedef struct packed {
      logic        req;
      logic        wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } bade_mem_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0000,
      ST_ADDR  = 4'b0001,
      ST_OP1A  = 4'b0011,
      ST_OP1B  = 4'b0010,
      ST_OP2A  = 4'b0110,
      ST_OP2B  = 4'b0111,
      ST_EXEC  = 4'b0101,
      ST_WR1   = 4'b0100,
      ST_WR2   = 4'b1100,
      ST_DONE  = 4'b1101
   } bade_state_t;
endpackage

// >>> design/bade_exec.sv
// Functional notes
// [RULE_01] one-word reg-reg add: opcode bits 0-7, first reg 9-11, second reg 13-15
// [RULE_02] reg-reg add operands come from register, or memory addressed by it if indirect
// [RULE_03] one-word sum goes to operand 2; bit 0 set on signed 16-bit overflow
// [RULE_04] every binary add clears condition bits 1, 2 and 4 to 7
// [RULE_05] one-word add sets link bit 3 when unsigned result exceeds 65535
// [RULE_06] two-word add reads 32-bit memory operand, high word first, indexed/indirect
// [RULE_07] direct two-word operand: named register high, next register low, 7 wraps to 0
// [RULE_08] indirect two-word operand: 32-bit field at register address, high word first
// [RULE_09] two-word sum stored at operand 2; bit 0 signed overflow, bit 3 carry out
// [RULE_10] memory divide reads 16-bit signed divisor at effective address
// [RULE_11] direct dividend: named register low, next lower register high, 0 wraps to 7
// [RULE_12] indirect dividend starts two bytes below register address, high half first
// [RULE_13] quotient to named register/address, remainder to lower register/two bytes below
// [RULE_14] remainder sign always follows the dividend sign
// [RULE_15] bit 0 set when quotient does not fit signed one-word range
// [RULE_16] zero divisor sets bit 0 and leaves both operands unchanged
// [RULE_17] divide without overflow or zero divisor clears bit 0
// [RULE_18] direct divide divisor is signed immediate from second word; bit 8 zero
// [RULE_19] indexed immediate adds first register, with no overflow or link check
// [RULE_20] immediate divide divisor is unsigned 4-bit value from bits 8-11
// [RULE_21] bit 8 is the first operand indirect flag, bit 12 the second
// [RULE_22] memory forms take base from second word, add first register if indexed
// [RULE_23] link set when unsigned add result exceeds its one- or two-word field
`include "bade_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module bade_exec
   import bade_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // instruction issue
   input  wire logic        start,
   input  wire bade_instr_t instrWord,
   input  wire logic [15:0] secondWord,
   input  wire logic [7:0]  condIn,
   output logic             busy,
   output logic             done,
   output logic [7:0]       condOut,
   output logic             illegalOp,
   // general register file
   output logic [2:0]       regRdAddrA,
   output logic [2:0]       regRdAddrB,
   input  wire logic [15:0] regRdDataA,
   input  wire logic [15:0] regRdDataB,
   output logic             regWrEn,
   output logic [2:0]       regWrAddr,
   output logic [15:0]      regWrData,
   // main storage, word access, one-cycle read latency
   output bade_mem_t        memReq,
   input  wire logic [15:0] memRdata
);

   ////////////////////////////////////////////////////////////////////////
   bade_state_t state;
   bade_instr_t ir;
   logic [15:0] imm;
   logic [15:0] ea1;
   logic [15:0] ea2;
   logic [15:0] op1;
   logic [31:0] op2;
   logic [15:0] quotR;
   logic [15:0] remR;
   logic [31:0] sumR;
   logic [15:0] op1Hi;
   logic [15:0] r2Val;
   logic [15:0] pairVal;
   logic        opMem;
   logic [7:0]  condR;
   logic [1:0]  step;

   function automatic logic isDiv(input logic [7:0] op);
      isDiv = (op == `BADE_OP_DIVMR) || (op == `BADE_OP_DIVDIR) || (op == `BADE_OP_DIVIMM);
   endfunction

   function automatic logic isKnown(input logic [7:0] op);
      isKnown = isDiv(op) || (op == `BADE_OP_ADDR) || (op == `BADE_OP_ADDTW);
   endfunction

   logic opDiv;
   logic opTw;
   logic opAdd1;
   logic op2Wide;
   assign opDiv   = isDiv(ir.opcode);
   assign opTw    = (ir.opcode == `BADE_OP_ADDTW);
   assign opAdd1  = (ir.opcode == `BADE_OP_ADDR);
   assign op2Wide = opDiv || opTw;
   assign opMem   = opTw || (ir.opcode == `BADE_OP_DIVMR);

   // second-operand register pair for wide forms
   logic [2:0] pairReg;
   always_comb
   begin
      pairReg = ir.secondRegField - 3'h1;                // [RULE_11]
      if (opTw)
      begin
         pairReg = ir.secondRegField + 3'h1;             // [RULE_07]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // arithmetic
   logic [16:0] sum1;
   logic [32:0] sum2;
   logic [15:0] divisor;
   logic        divZero;
   logic [31:0] dvdMag;
   logic [15:0] dvsMag;
   logic [31:0] qMag;
   logic [15:0] rMag;
   logic [31:0] qSigned;
   logic        qOvf;
   logic        ovf1;
   logic        ovf2;

   assign sum1 = {1'b0, op1} + {1'b0, op2[15:0]};
   assign sum2 = {1'b0, op2} + {1'b0, op1Hi, op1};
   assign ovf1 = (op1[15] == op2[15]) && (sum1[15] != op1[15]);     // [RULE_03]
   assign ovf2 = (op1Hi[15] == op2[31]) && (sum2[31] != op1Hi[15]); // [RULE_09]

   always_comb
   begin
      divisor = op1;
      if (ir.opcode == `BADE_OP_DIVIMM)
      begin
         divisor = {12'h000, ir.ind1, ir.firstRegField};             // [RULE_20]
      end
   end
   assign divZero = (divisor == 16'h0000);                           // [RULE_16]
   assign dvdMag  = op2[31] ? (32'h00000000 - op2) : op2;
   assign dvsMag  = divisor[15] ? (16'h0000 - divisor) : divisor;
   assign qMag    = divZero ? 32'h00000000 : dvdMag / {16'h0000, dvsMag};
   assign rMag    = divZero ? 16'h0000 : 16'(dvdMag % {16'h0000, dvsMag});
   assign qSigned = (op2[31] ^ divisor[15]) ? (32'h00000000 - qMag) : qMag;
   assign qOvf    = (qSigned[31:15] != {17{qSigned[15]}});           // [RULE_15]

   ////////////////////////////////////////////////////////////////////////
   // fetch plan of the current state: words to read and first address
   logic [1:0]  fetchWords;
   logic [15:0] fetchAddr;
   logic        fetchLast;
   logic        capHi;
   logic        capLo;
   always_comb
   begin
      fetchWords = 2'h0;
      fetchAddr  = ea1;
      if (state == ST_OP1A && ir.ind1 && opMem)
      begin
         fetchWords = 2'h1;                                          // [RULE_21]
      end
      else if (state == ST_OP1B && (opMem || (opAdd1 && ir.ind1)))
      begin
         fetchWords = opTw ? 2'h2 : 2'h1;                            // [RULE_06] [RULE_10]
      end
      else if (state == ST_OP2A && ir.ind2)
      begin
         // dividend starts one word below the pointer
         fetchAddr  = opDiv ? ea2 - `BADE_WORD_STEP : ea2;           // [RULE_12]
         fetchWords = op2Wide ? 2'h2 : 2'h1;                         // [RULE_08]
      end
   end
   // reads are pipelined: issued at steps 0 and 1, returned at steps 2 and 3
   assign fetchLast = (fetchWords == 2'h0) || (step == fetchWords + 2'h1);
   assign capHi     = (fetchWords != 2'h0) && (step == 2'h2);
   assign capLo     = (fetchWords == 2'h2) && (step == 2'h3);

   // write slot: quotient or high word first, then remainder or low word
   logic [2:0]  wrReg;
   logic [15:0] wrAddr;
   logic [15:0] wrData;
   always_comb
   begin
      wrReg  = ir.secondRegField;
      wrAddr = ea2;
      wrData = opDiv ? quotR : (opTw ? sumR[31:16] : sumR[15:0]);   // [RULE_13]
      if (state == ST_WR2)
      begin
         wrReg  = pairReg;                                           // [RULE_07]
         wrAddr = opDiv ? ea2 - `BADE_WORD_STEP : ea2 + `BADE_WORD_STEP; // [RULE_13]
         wrData = opDiv ? remR : sumR[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state <= ST_IDLE;
         step  <= 2'h0;
      end
      else
      begin
         unique case (state)
            ST_IDLE: if (start) state <= isKnown(instrWord.opcode) ? ST_ADDR : ST_DONE;
            ST_ADDR: state <= ST_OP1A;
            ST_OP1A: if (fetchLast) state <= ST_OP1B;
            ST_OP1B: if (fetchLast) state <= ST_OP2A;
            ST_OP2A: if (fetchLast) state <= ST_OP2B;
            ST_OP2B: state <= ST_EXEC;
            // a zero divisor skips the write slots so both operands stay
            ST_EXEC: state <= (opDiv && divZero) ? ST_DONE : ST_WR1;    // [RULE_16]
            ST_WR1:  state <= op2Wide ? ST_WR2 : ST_DONE;
            ST_WR2:  state <= ST_DONE;
            ST_DONE: state <= ST_IDLE;
            default: state <= ST_IDLE;
         endcase
         step <= fetchLast ? 2'h0 : step + 2'h1;
      end
   end

   // capture instruction, form effective addresses
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ir  <= '0;
         imm <= 16'h0000;
         ea1 <= 16'h0000;
      end
      else if (state == ST_IDLE && start)
      begin
         ir  <= instrWord;                                           // [RULE_01]
         imm <= secondWord;
      end
      else if (state == ST_ADDR)
      begin
         // indexing register zero means no index, as in the base address forms
         ea1 <= imm + ((ir.firstRegField != 3'h0) ? regRdDataA : 16'h0000); // [RULE_19] [RULE_22]
         if (opAdd1)
         begin
            ea1 <= regRdDataA;                                       // [RULE_02]
         end
      end
      else if (state == ST_OP1A && capHi)
      begin
         ea1 <= memRdata;                                            // [RULE_21]
      end
   end

   // operand fetch
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         op1     <= 16'h0000;
         op1Hi   <= 16'h0000;
         op2     <= 32'h00000000;
         ea2     <= 16'h0000;
         r2Val   <= 16'h0000;
         pairVal <= 16'h0000;
      end
      else
      begin
         if (state == ST_ADDR)
         begin
            op1   <= regRdDataA;                                     // [RULE_02]
            r2Val <= regRdDataB;
            ea2   <= regRdDataB;                                     // [RULE_08] [RULE_12]
         end
         if (state == ST_OP1A)
         begin
            pairVal <= regRdDataB;                                   // [RULE_07] [RULE_11]
         end
         if (state == ST_OP1B)
         begin
            if (ir.opcode == `BADE_OP_DIVDIR)
            begin
               op1 <= ea1;                                           // [RULE_18]
            end
            if (capHi && opTw)
            begin
               op1Hi <= memRdata;                                    // [RULE_06]
            end
            else if (capHi || capLo)
            begin
               op1 <= memRdata;                                      // [RULE_02] [RULE_10]
            end
         end
         if (state == ST_OP2A && capHi)
         begin
            if (op2Wide)
            begin
               op2[31:16] <= memRdata;                               // [RULE_08] [RULE_12]
            end
            else
            begin
               op2[15:0] <= memRdata;                                // [RULE_02]
            end
         end
         if (state == ST_OP2A && capLo)
         begin
            op2[15:0] <= memRdata;                                   // [RULE_08] [RULE_12]
         end
         if (state == ST_OP2B && !ir.ind2)
         begin
            op2 <= {16'h0000, r2Val};                                // [RULE_02]
            if (opTw)
            begin
               op2 <= {r2Val, pairVal};                              // [RULE_07]
            end
            else if (opDiv)
            begin
               op2 <= {pairVal, r2Val};                              // [RULE_11]
            end
         end
      end
   end

   // results and condition bits
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         condR     <= `BADE_CC_RESET;
         sumR      <= 32'h00000000;
         quotR     <= 16'h0000;
         remR      <= 16'h0000;
      end
      else if (state == ST_IDLE && start)
      begin
         condR <= condIn;
      end
      else if (state == ST_EXEC)
      begin
         if (opDiv)
         begin
            condR[`BADE_CC_OVF] <= divZero || qOvf;                  // [RULE_15] [RULE_16] [RULE_17]
            quotR <= qSigned[15:0];
            remR  <= op2[31] ? (16'h0000 - rMag) : rMag;             // [RULE_14]
         end
         else
         begin
            condR <= `BADE_CC_RESET;                                 // [RULE_04]
            if (opTw)
            begin
               sumR <= sum2[31:0];
               condR[`BADE_CC_OVF]  <= ovf2;                         // [RULE_09]
               condR[`BADE_CC_LINK] <= (sum2 > `BADE_DWORD_MAX);     // [RULE_09] [RULE_23]
            end
            else
            begin
               sumR <= {16'h0000, sum1[15:0]};                       // [RULE_03]
               condR[`BADE_CC_OVF]  <= ovf1;                         // [RULE_03]
               condR[`BADE_CC_LINK] <= (sum1 > `BADE_WORD_MAX);      // [RULE_05] [RULE_23]
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // port drive: register file addresses and memory requests
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         regRdAddrA <= 3'h0;
         regRdAddrB <= 3'h0;
         regWrEn    <= 1'b0;
         regWrAddr  <= 3'h0;
         regWrData  <= 16'h0000;
         memReq     <= '0;
         busy       <= 1'b0;
         done       <= 1'b0;
         condOut    <= `BADE_CC_RESET;
         illegalOp  <= 1'b0;
      end
      else
      begin
         regWrEn   <= 1'b0;
         memReq    <= '0;
         done      <= (state == ST_DONE);
         busy      <= (state != ST_IDLE) && (state != ST_DONE);
         if (state == ST_IDLE && start)
         begin
            regRdAddrA <= instrWord.firstRegField;                   // [RULE_01]
            regRdAddrB <= instrWord.secondRegField;
            illegalOp  <= !isKnown(instrWord.opcode);
            condOut    <= condIn;
         end
         if (state == ST_ADDR)
         begin
            regRdAddrB <= pairReg;                                   // [RULE_07] [RULE_11]
         end
         if (fetchWords != 2'h0 && step == 2'h0)
         begin
            memReq <= '{1'b1, 1'b0, fetchAddr, 16'h0000};
         end
         if (fetchWords == 2'h2 && step == 2'h1)
         begin
            memReq <= '{1'b1, 1'b0, fetchAddr + `BADE_WORD_STEP, 16'h0000}; // [RULE_06]
         end
         if ((state == ST_WR1 || state == ST_WR2) && ir.ind2)
         begin
            memReq <= '{1'b1, 1'b1, wrAddr, wrData};                 // [RULE_13]
         end
         else if (state == ST_WR1 || state == ST_WR2)
         begin
            regWrEn   <= 1'b1;
            regWrAddr <= wrReg;
            regWrData <= wrData;                                     // [RULE_03] [RULE_09]
         end
         if (state == ST_DONE)
         begin
            condOut <= condR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   localparam logic [7:0] ADD_KEEP = (8'h01 << `BADE_CC_OVF) | (8'h01 << `BADE_CC_LINK);

   sequence s_zeroDivide;
      (state == ST_EXEC) && opDiv && divZero;
   endsequence

   sequence s_quietFinish;
      (state == ST_DONE) ##1 (done && !regWrEn && !memReq.req && condOut[`BADE_CC_OVF]);
   endsequence

   chk_zero_divide: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_16]
      s_zeroDivide |=> s_quietFinish)
      else $error("zero divisor touched an operand");

   chk_add_clear: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_04]
      (state == ST_DONE && isKnown(ir.opcode) && !opDiv) |=> ((condOut & ~ADD_KEEP) == 8'h00))
      else $error("add left condition bits set");

   chk_link_word: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_05]
      (state == ST_EXEC && opAdd1) |=> (condR[`BADE_CC_LINK] == sum1[16]))
      else $error("one-word link wrong");

   chk_link_dword: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_09]
      (state == ST_EXEC && opTw) |=> (condR[`BADE_CC_LINK] == sum2[32]))
      else $error("two-word link wrong");

   chk_quot_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_13]
      (state == ST_WR1 && opDiv && !ir.ind2) |=>
         (regWrEn && regWrAddr == ir.secondRegField && regWrData == quotR))
      else $error("quotient not written to named register");

   chk_rem_sign: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_14]
      (state == ST_WR2 && opDiv && rMag != 16'h0000) |-> (remR[15] == op2[31]))
      else $error("remainder sign differs from dividend");

   chk_pair_wrap: assert property (@(posedge clk) disable iff (sys_rst) // [RULE_07]
      (state == ST_WR2 && opTw && !ir.ind2) |=>
         (regWrEn && regWrAddr == ir.secondRegField + 3'h1))
      else $error("low word not in next register");

endmodule
`default_nettype wire

// >>> tb/bade_store_model.sv
`timescale 1ns/100ps
`default_nettype none

module bade_store_model
   import bade_pkg::*;
(
   // clock
   input  wire logic        clk,
   // main storage, word access
   input  wire bade_mem_t   memReq,
   output logic [15:0]      memRdata,
   // general register file
   input  wire logic [2:0]  regRdAddrA,
   input  wire logic [2:0]  regRdAddrB,
   output logic [15:0]      regRdDataA,
   output logic [15:0]      regRdDataB,
   input  wire logic        regWrEn,
   input  wire logic [2:0]  regWrAddr,
   input  wire logic [15:0] regWrData
);
   logic [15:0] mem [0:255];
   logic [15:0] regs [0:7];
   logic        rdPend = 1'b0;
   logic [15:0] rdWord = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   assign regRdDataA = regs[regRdAddrA];
   assign regRdDataB = regs[regRdAddrB];

   // byte addresses, even only; small store keeps the bench cheap
   always @(posedge clk)
   begin
      rdPend <= memReq.req && !memReq.wr;
      if (memReq.req && !memReq.wr)
         rdWord <= mem[memReq.addr[8:1]];
      if (memReq.req && memReq.wr)
         mem[memReq.addr[8:1]] <= memReq.wdata;
      if (regWrEn)
         regs[regWrAddr] <= regWrData;
   end

   // outside the read slot the bus shows the inverse of its last word
   assign memRdata = rdPend ? rdWord : ~rdWord;
endmodule

`default_nettype wire

// >>> tb/testbench.sv
`include "bade_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module testbench
   import bade_pkg::*;
;
   logic        clk = 1'b0;
   logic        sysRst = 1'b1;
   logic        start = 1'b0;
   bade_instr_t instrWord = '0;
   logic [15:0] secondWord = 16'h0000;
   logic [7:0]  condIn = 8'h00;
   logic        busy;
   logic        done;
   logic [7:0]  condOut;
   logic        illegalOp;
   logic [2:0]  regRdAddrA;
   logic [2:0]  regRdAddrB;
   logic [15:0] regRdDataA;
   logic [15:0] regRdDataB;
   logic        regWrEn;
   logic [2:0]  regWrAddr;
   logic [15:0] regWrData;
   bade_mem_t   memReq;
   logic [15:0] memRdata;
   int          miscompares = 0;
   int          cmpCount = 0;

   always #12.5 clk = ~clk;

   bade_exec i_bade_exec (.clk(clk), .sys_rst(sysRst), .start(start), .instrWord(instrWord),
      .secondWord(secondWord), .condIn(condIn), .busy(busy), .done(done), .condOut(condOut),
      .illegalOp(illegalOp), .regRdAddrA(regRdAddrA), .regRdAddrB(regRdAddrB),
      .regRdDataA(regRdDataA), .regRdDataB(regRdDataB), .regWrEn(regWrEn),
      .regWrAddr(regWrAddr), .regWrData(regWrData), .memReq(memReq), .memRdata(memRdata));

   bade_store_model i_bade_store_model (.clk(clk), .memReq(memReq), .memRdata(memRdata),
      .regRdAddrA(regRdAddrA), .regRdAddrB(regRdAddrB), .regRdDataA(regRdDataA),
      .regRdDataB(regRdDataB), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
      .regWrData(regWrData));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmpCount++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic sr(input int idx, input logic [15:0] val);
      i_bade_store_model.regs[idx] = val;
   endtask

   task automatic sm(input int addr, input logic [15:0] val);
      i_bade_store_model.mem[addr/2] = val;
   endtask

   function automatic logic [15:0] gr(input int idx);
      return i_bade_store_model.regs[idx];
   endfunction

   function automatic logic [15:0] gm(input int addr);
      return i_bade_store_model.mem[addr/2];
   endfunction

   function automatic bade_instr_t mk(input logic [7:0] op, input logic a, input logic [2:0] b,
                                      input logic c, input logic [2:0] d);
      return '{op, a, b, c, d};
   endfunction

   // expected condition after an add: only overflow and link may be set
   function automatic logic [7:0] cc(input logic ovf, input logic lnk);
      return (8'(ovf) << `BADE_CC_OVF) | (8'(lnk) << `BADE_CC_LINK);
   endfunction

   function automatic logic [7:0] cd(input logic [7:0] ci, input logic ovf);
      return ovf ? (ci | (8'h01 << `BADE_CC_OVF)) : (ci & ~(8'h01 << `BADE_CC_OVF));
   endfunction

   // one issue, then a bounded wait for the completion pulse
   task automatic run(input bade_instr_t iw, input logic [15:0] sw, input logic [7:0] ci);
      int n;
      @(posedge clk);
      instrWord <= iw;
      secondWord <= sw;
      condIn <= ci;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      n = 0;
      #1;
      while (done !== 1'b1 && n < 30)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      check(32'(done), 32'h1, "done");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_add_reg;
      sr(1, 16'h7fff);
      sr(3, 16'h0001);
      run(mk(`BADE_OP_ADDR, 1'b0, 3'h1, 1'b0, 3'h3), 16'h0000, 8'hff);
      check(32'(gr(3)), 32'h8000, "add sum");
      check(32'(gr(1)), 32'h7fff, "add op1 kept");
      check(32'(condOut), 32'(cc(1'b1, 1'b0)), "add cond");
      sr(4, 16'hffff);
      sr(5, 16'h0002);
      run(mk(`BADE_OP_ADDR, 1'b0, 3'h4, 1'b0, 3'h5), 16'h0000, 8'hff);
      check(32'(gr(5)), 32'h0001, "add wrap sum");
      check(32'(condOut), 32'(cc(1'b0, 1'b1)), "add link");
   endtask

   task automatic t_add_ind;
      sr(1, 16'h0010);
      sr(2, 16'h0020);
      sm(16'h10, 16'h8000);
      sm(16'h20, 16'hffff);
      run(mk(`BADE_OP_ADDR, 1'b1, 3'h1, 1'b1, 3'h2), 16'h0000, 8'h00);
      check(32'(gm(16'h20)), 32'h7fff, "ind sum");
      check(32'(gr(2)), 32'h0020, "ind ptr kept");
      check(32'(condOut), 32'(cc(1'b1, 1'b1)), "ind cond");
   endtask

   task automatic t_add_two_dir;
      sr(2, 16'h0010);
      sm(16'h40, 16'h7fff);
      sm(16'h42, 16'hffff);
      sr(7, 16'h0000);
      sr(0, 16'h0001);
      run(mk(`BADE_OP_ADDTW, 1'b0, 3'h2, 1'b0, 3'h7), 16'h0030, 8'hff);
      check(32'({gr(7), gr(0)}), 32'h80000000, "two-word sum");
      check(32'(condOut), 32'(cc(1'b1, 1'b0)), "two-word ovf");
   endtask

   task automatic t_add_two_ind;
      sm(16'h50, 16'h0080);
      sm(16'h80, 16'hffff);
      sm(16'h82, 16'hffff);
      sr(3, 16'h0060);
      sm(16'h60, 16'h0000);
      sm(16'h62, 16'h0001);
      run(mk(`BADE_OP_ADDTW, 1'b1, 3'h0, 1'b1, 3'h3), 16'h0050, 8'h00);
      check(32'({gm(16'h60), gm(16'h62)}), 32'h0, "two-word ind sum");
      check(32'(condOut), 32'(cc(1'b0, 1'b1)), "two-word link");
   endtask

   task automatic t_div_mem;
      sr(7, 16'hffff);
      sr(0, 16'hfff9);
      sm(16'h70, 16'h0002);
      run(mk(`BADE_OP_DIVMR, 1'b0, 3'h0, 1'b0, 3'h0), 16'h0070, 8'hff);
      check(32'(gr(0)), 32'hfffd, "quotient");
      check(32'(gr(7)), 32'hffff, "remainder sign");
      check(32'(condOut), 32'(cd(8'hff, 1'b0)), "div cond");
      sm(16'h70, 16'h0000);
      run(mk(`BADE_OP_DIVMR, 1'b0, 3'h0, 1'b0, 3'h0), 16'h0070, 8'h00);
      check(32'({gr(7), gr(0)}), 32'hfffffffd, "zero divisor kept");
      check(32'(condOut), 32'(cd(8'h00, 1'b1)), "zero divisor cond");
   endtask

   task automatic t_div_direct;
      sr(1, 16'h0003);
      sr(4, 16'h0104);
      sm(16'h102, 16'h0000);
      sm(16'h104, 16'h0007);
      run(mk(`BADE_OP_DIVDIR, 1'b0, 3'h1, 1'b1, 3'h4), 16'hfffb, 8'h01);
      check(32'(gm(16'h104)), 32'hfffd, "imm quotient");
      check(32'(gm(16'h102)), 32'h0001, "imm remainder");
      check(32'(condOut), 32'(cd(8'h01, 1'b0)), "imm cond");
      sr(5, 16'h0001);
      sr(6, 16'h0000);
      run(mk(`BADE_OP_DIVDIR, 1'b0, 3'h0, 1'b0, 3'h6), 16'h0001, 8'h00);
      check(32'(condOut), 32'(cd(8'h00, 1'b1)), "quotient overflow");
   endtask

   task automatic t_div_small;
      sr(4, 16'h0000);
      sr(5, 16'h0064);
      // bits 8-11 all ones: divisor fifteen, never negative
      run(mk(`BADE_OP_DIVIMM, 1'b1, 3'h7, 1'b0, 3'h5), 16'h0000, 8'h01);
      check(32'(gr(5)), 32'h0006, "small quotient");
      check(32'(gr(4)), 32'h000a, "small remainder");
      check(32'(condOut), 32'(cd(8'h01, 1'b0)), "small cond");
   endtask

   task automatic t_refused;
      sr(1, 16'h1234);
      run(mk(8'h00, 1'b0, 3'h1, 1'b0, 3'h1), 16'h0000, 8'h5a);
      check(32'(illegalOp), 32'h1, "unknown opcode");
      check(32'(gr(1)), 32'h1234, "unknown opcode no write");
      sr(2, 16'h0001);
      @(posedge clk);
      instrWord <= mk(`BADE_OP_ADDR, 1'b0, 3'h2, 1'b0, 3'h1);
      start <= 1'b1;
      // a second start while busy must be ignored
      @(posedge clk);
      instrWord <= mk(8'h00, 1'b0, 3'h2, 1'b0, 3'h1);
      run(mk(`BADE_OP_ADDR, 1'b0, 3'h0, 1'b0, 3'h0), 16'h0000, 8'h00);
      check(32'(gr(1)), 32'h1235, "busy start ignored");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (4) @(posedge clk);
      sysRst <= 1'b0;
      #1;
      check(32'({busy, done, condOut, memReq.req, regWrEn}), 32'h0, "reset state");
      t_add_reg();
      t_add_ind();
      t_add_two_dir();
      t_add_two_ind();
      t_div_mem();
      t_div_direct();
      t_div_small();
      t_refused();
      results();
   end

   initial
   begin
      #(25 * 3000);
      miscompares++;
      results();
   end
endmodule

`default_nettype wire
